/* File: rtl/pbcs_params.svh */
// constants for the pll base clock selector: offsets, fields, reset values, counts
`ifndef PBCS_PARAMS_SVH
`define PBCS_PARAMS_SVH

`define PBCS_ADDR_CTRL 8'h36
`define PBCS_ADDR_MUL_HIGH 8'h38
`define PBCS_ADDR_MUL_LOW 8'h39
`define PBCS_ADDR_RANGE 8'h3A

`define PBCS_BIT_PLL_ON 5
`define PBCS_BIT_BCS 4
`define PBCS_VPR_MSB 1
`define PBCS_VPR_LSB 0

`define PBCS_RST_PLL_ON 1'b1
`define PBCS_RST_BCS 1'b0
`define PBCS_RST_VPR 2'h0
`define PBCS_RST_MUL_HIGH 4'h0
`define PBCS_RST_MUL_LOW 8'h40
`define PBCS_RST_RANGE 8'h40

`define PBCS_XTAL_WAIT 2'h3
`define PBCS_VCO_WAIT 2'h3
`define PBCS_NOMINAL_CENTER_FREQ_HZ 71400

`endif

/* File: rtl/pbcs_pkg.sv */
// types shared by the pll base clock selector
package pbcs_pkg;
  typedef enum logic [1:0] {
    PBCS_RUN = 2'b01,
    PBCS_HOLD = 2'b10
  } pbcs_state_e;
  typedef logic [1:0] pbcs_clk_t; // bit 1 vco, bit 0 crystal
endpackage : pbcs_pkg

/* File: rtl/pbcs_top.sv */
// pll programming registers and glitch-free base clock selector
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "pbcs_params.svh"

module pbcs_top import pbcs_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic sysint_osc_enable,
  output logic osc_enable_out,
  output logic pll_enable_out,
  output logic base_clock_out,
  output logic base_is_vco,
  output logic vco_feedback_pulse,
  output logic [11:0] feedback_divisor,
  output logic [10:0] center_range_code
);

  logic pll_power_enable;
  logic base_source_select;
  logic [1:0] vco_range_exponent_bits;
  logic [3:0] multiplier_high_reg;
  logic [7:0] multiplier_low_reg;
  logic [7:0] vco_range_reg;
  logic next_pll_on;
  logic next_bcs;
  logic wr_ctrl;
  logic l_zero;
  logic osc_s1;
  logic osc_s2;
  pbcs_clk_t clk_s1;
  pbcs_clk_t clk_s2;
  pbcs_clk_t clk_s3;
  pbcs_clk_t clk_rise;
  pbcs_state_e state;
  logic [1:0] x_cnt;
  logic [1:0] v_cnt;
  logic [11:0] fb_cnt;
  logic [11:0] n_raw;

  assign wr_ctrl = reg_wr && (reg_addr == `PBCS_ADDR_CTRL);
  assign l_zero = (vco_range_reg == 8'h00);
  assign n_raw = {multiplier_high_reg, multiplier_low_reg};
  assign clk_rise = clk_s2 & ~clk_s3;

  // interlocks between power enable and base select
  always_comb begin
    next_pll_on = pll_power_enable;
    next_bcs = base_source_select;
    if (wr_ctrl) begin
      next_pll_on = reg_wdata[`PBCS_BIT_PLL_ON] | base_source_select;
      // a select change rides only on a write that leaves power alone
      if (next_pll_on == pll_power_enable) begin
        next_bcs = reg_wdata[`PBCS_BIT_BCS] & pll_power_enable & ~l_zero;
      end
    end
    // range zero beats any write: the crystal must stay in charge
    if (l_zero) begin
      next_bcs = 1'b0;
    end
  end

  // control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll_power_enable <= `PBCS_RST_PLL_ON;
      base_source_select <= `PBCS_RST_BCS;
      vco_range_exponent_bits <= `PBCS_RST_VPR;
    end else begin
      pll_power_enable <= next_pll_on;
      base_source_select <= next_bcs;
      // exponent locked while powered, so the loop never sees its range move
      if (wr_ctrl && !pll_power_enable) begin
        vco_range_exponent_bits <= reg_wdata[`PBCS_VPR_MSB:`PBCS_VPR_LSB];
      end
    end
  end

  // multiplier and range registers; writable at any time
  // a new divisor is picked up by the next feedback count, no retiming needed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      multiplier_high_reg <= `PBCS_RST_MUL_HIGH;
      multiplier_low_reg <= `PBCS_RST_MUL_LOW;
      vco_range_reg <= `PBCS_RST_RANGE;
    end else if (reg_wr) begin
      if (reg_addr == `PBCS_ADDR_MUL_HIGH) begin
        multiplier_high_reg <= reg_wdata[3:0];
      end
      if (reg_addr == `PBCS_ADDR_MUL_LOW) begin
        multiplier_low_reg <= reg_wdata;
      end
      if (reg_addr == `PBCS_ADDR_RANGE) begin
        vco_range_reg <= reg_wdata;
      end
    end
  end

  // read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PBCS_ADDR_CTRL: reg_rdata <= {2'h0, pll_power_enable, base_source_select, 2'h0, vco_range_exponent_bits};
        `PBCS_ADDR_MUL_HIGH: reg_rdata <= {4'h0, multiplier_high_reg};
        `PBCS_ADDR_MUL_LOW: reg_rdata <= multiplier_low_reg;
        `PBCS_ADDR_RANGE: reg_rdata <= vco_range_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // two-stage synchronisers for both clocks and the oscillator enable
  // the third clock stage only feeds the edge detector
  // limitation: each source level must last longer than one clk_sys cycle to be seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_s1 <= 2'h0;
      clk_s2 <= 2'h0;
      clk_s3 <= 2'h0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
    end else begin
      clk_s1 <= {vco_clock, crystal_clock};
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      osc_s1 <= sysint_osc_enable;
      osc_s2 <= osc_s1;
    end
  end

  // oscillator and pll gating
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_enable_out <= 1'b0;
      pll_enable_out <= 1'b0;
    end else begin
      osc_enable_out <= osc_s2;
      // range zero also keeps the pll gate shut
      pll_enable_out <= osc_s2 & pll_power_enable & ~l_zero;
    end
  end

  // transition control: a stopped vco is not waited on, else a forced
  // return to crystal after the pll drops would hang the switch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= PBCS_RUN;
      base_is_vco <= 1'b0;
      x_cnt <= 2'h0;
      v_cnt <= 2'h0;
    end else begin
      unique case (state)
        PBCS_RUN: begin
          x_cnt <= 2'h0;
          v_cnt <= 2'h0;
          if (base_source_select != base_is_vco) begin
            state <= PBCS_HOLD;
          end
        end
        PBCS_HOLD: begin
          // counts saturate, so a long hold never wraps the wait
          if (clk_rise[0] && x_cnt != `PBCS_XTAL_WAIT) begin
            x_cnt <= x_cnt + 2'h1;
          end
          if (clk_rise[1] && v_cnt != `PBCS_VCO_WAIT) begin
            v_cnt <= v_cnt + 2'h1;
          end
          if (x_cnt == `PBCS_XTAL_WAIT && (v_cnt == `PBCS_VCO_WAIT || !pll_enable_out)) begin
            base_is_vco <= base_source_select;
            state <= PBCS_RUN;
          end
        end
        default: state <= PBCS_RUN;
      endcase
    end
  end

  // divide the chosen source by two; frozen during the hold
  // toggling on source edges halves the rate and evens the duty cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_clock_out <= 1'b0;
    end else if (state == PBCS_RUN && clk_rise[base_is_vco]) begin
      base_clock_out <= ~base_clock_out;
    end
  end

  // effective divisor, centre code and the vco feedback divider
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      feedback_divisor <= 12'h001;
      center_range_code <= 11'h000;
      fb_cnt <= 12'h000;
      vco_feedback_pulse <= 1'b0;
    end else begin
      // zero read as one, so the divider never stalls
      feedback_divisor <= (n_raw == 12'h000) ? 12'h001 : n_raw;
      center_range_code <= 11'({3'h0, vco_range_reg} << vco_range_exponent_bits);
      vco_feedback_pulse <= 1'b0;
      // compares against the registered divisor, one cycle behind writes
      if (clk_rise[1] && pll_enable_out) begin
        if (fb_cnt + 12'h001 >= feedback_divisor) begin
          fb_cnt <= 12'h000;
          vco_feedback_pulse <= 1'b1;
        end else begin
          fb_cnt <= fb_cnt + 12'h001;
        end
      end
    end
  end

  // checks
  // all on the system clock and quiet during reset
  chk_div_zero_one: assert property (@(posedge clk_sys) disable iff (rst)
    $past(n_raw) == 12'h000 && !$past(rst) |-> feedback_divisor == 12'h001)
    else $error("zero divisor not treated as one");
  chk_l_zero_off: assert property (@(posedge clk_sys) disable iff (rst)
    l_zero |=> !pll_enable_out && !base_source_select)
    else $error("range zero left pll or vco select on");
  chk_hold_frozen: assert property (@(posedge clk_sys) disable iff (rst)
    state == PBCS_HOLD |=> $stable(base_clock_out))
    else $error("base clock moved during hold");
  chk_base_toggle: assert property (@(posedge clk_sys) disable iff (rst)
    state == PBCS_RUN && clk_rise[base_is_vco] |=> base_clock_out != $past(base_clock_out))
    else $error("base clock missed a source edge");
  chk_vco_refused: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ctrl && !pll_power_enable |=> !base_source_select)
    else $error("vco selected with pll off");
  chk_pll_power_enable_kept: assert property (@(posedge clk_sys) disable iff (rst)
    base_source_select && wr_ctrl |=> pll_power_enable)
    else $error("pll switched off under vco");
  chk_no_joint_change: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(pll_power_enable) |-> $stable(base_source_select))
    else $error("power and select changed together");
  chk_vpr_locked: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ctrl && pll_power_enable |=> $stable(vco_range_exponent_bits))
    else $error("range exponent written while pll on");
  chk_osc_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !osc_s2 |=> !pll_enable_out && !osc_enable_out)
    else $error("pll or oscillator on without enable");
  chk_switch_done: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(base_is_vco) |-> $past(state) == PBCS_HOLD && $past(x_cnt) == `PBCS_XTAL_WAIT)
    else $error("source changed outside a completed hold");
  // only edges of the routed source may move the output
  chk_base_source: assert property (@(posedge clk_sys) disable iff (rst)
    state == PBCS_RUN && !clk_rise[base_is_vco] |=> $stable(base_clock_out))
    else $error("base clock moved without a routed source edge");
  // each feedback pulse stems from a seen vco edge with the pll running
  chk_fb_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    vco_feedback_pulse |-> $past(clk_rise[1]) && $past(pll_enable_out))
    else $error("feedback pulse without a vco edge");
  // the vco is never selected with power off
  chk_vco_needs_pll: assert property (@(posedge clk_sys) disable iff (rst)
    base_source_select |-> pll_power_enable)
    else $error("vco selected while pll power is off");
  // exponent reads back as plain binary in the low control bits
  chk_ctrl_read: assert property (@(posedge clk_sys) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == `PBCS_ADDR_CTRL
    |-> reg_rdata[`PBCS_VPR_MSB:`PBCS_VPR_LSB] == $past(vco_range_exponent_bits))
    else $error("exponent read back wrong");

  cov_to_vco: cover property (@(posedge clk_sys) disable iff (rst) $rose(base_is_vco));
  cov_to_xtal: cover property (@(posedge clk_sys) disable iff (rst) $fell(base_is_vco));
  cov_refused: cover property (@(posedge clk_sys) disable iff (rst)
    wr_ctrl && reg_wdata[`PBCS_BIT_BCS] && !pll_power_enable);
  // forced return to crystal with the vco stopped
  cov_hold_pll_off: cover property (@(posedge clk_sys) disable iff (rst)
    state == PBCS_HOLD && !pll_enable_out ##1 state == PBCS_RUN);
  cov_fb_pulse: cover property (@(posedge clk_sys) disable iff (rst) vco_feedback_pulse);

endmodule : pbcs_top

/* File: tb/pbcs_osc_model.sv */
// far-side oscillator model: crystal and vco sources feeding the selector
`timescale 1ns/1ps

module pbcs_osc_model #(
  parameter real XTAL_HALF_NS = 85.0,
  // vco near 24 MHz, so the bench's exponent of two fits its band
  parameter real VCO_HALF_NS = 20.7
) (
  input wire logic osc_en,
  input wire logic pll_en,
  output logic xtal,
  output logic vco
);
  // crystal stands still while the oscillator is gated off
  initial begin
    xtal = 1'b0;
    forever begin
      #(XTAL_HALF_NS);
      xtal = osc_en ? ~xtal : 1'b0;
    end
  end
  // vco stands still while the pll is disabled, so no stray edges reach the hold counter
  initial begin
    vco = 1'b0;
    forever begin
      #(VCO_HALF_NS);
      vco = pll_en ? ~vco : 1'b0;
    end
  end
endmodule : pbcs_osc_model

/* File: tb/tb.sv */
// self-checking bench for the pll base clock selector with a register-level model
`timescale 1ns/1ps
`include "pbcs_params.svh"

module tb;
  logic clk_sys, rst, reg_wr, reg_rd, crystal_clock, vco_clock, sysint_osc_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic osc_enable_out, pll_enable_out, base_clock_out, base_is_vco, vco_feedback_pulse;
  logic [11:0] feedback_divisor;
  logic [10:0] center_range_code;
  int fails, total_checks, seed, xr, vr, br, i, fp;
  logic m_on, m_bcs;
  logic [1:0] m_vpr;
  logic [7:0] m_lo, m_rg;
  logic [3:0] m_hi;

  pbcs_top i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .sysint_osc_enable(sysint_osc_enable), .osc_enable_out(osc_enable_out),
    .pll_enable_out(pll_enable_out), .base_clock_out(base_clock_out), .base_is_vco(base_is_vco),
    .vco_feedback_pulse(vco_feedback_pulse), .feedback_divisor(feedback_divisor),
    .center_range_code(center_range_code));
  pbcs_osc_model i_osc (.osc_en(osc_enable_out), .pll_en(pll_enable_out), .xtal(crystal_clock),
    .vco(vco_clock));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // edge counters for the divide-by-two comparison
  always @(posedge crystal_clock) xr++;
  always @(posedge vco_clock) vr++;
  always @(base_clock_out) br++;
  // pulses counted mid-cycle, clear of the edge where the count is reset
  always @(negedge clk_sys) if (vco_feedback_pulse) fp++;

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  function automatic logic [7:0] model_rd(input logic [7:0] a);
    case (a)
      8'h36: model_rd = {2'h0, m_on, m_bcs, 2'h0, m_vpr};
      8'h38: model_rd = {4'h0, m_hi};
      8'h39: model_rd = m_lo;
      8'h3A: model_rd = m_rg;
      default: model_rd = 8'h00;
    endcase
  endfunction : model_rd

  // one-cycle write strobe; model applies the interlocks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic on_n, bcs_n;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    on_n = d[5];
    bcs_n = d[4];
    if (a == 8'h36) begin
      if (m_bcs && !on_n) on_n = 1'b1;
      if (on_n != m_on) bcs_n = m_bcs;
      if (!on_n || m_rg == 8'h00) bcs_n = 1'b0;
      if (!m_on) m_vpr = d[1:0];
      m_on = on_n;
      m_bcs = bcs_n;
    end
    if (a == 8'h38) m_hi = d[3:0];
    if (a == 8'h39) m_lo = d;
    if (a == 8'h3A) m_rg = d;
    if (a == 8'h3A && d == 8'h00) m_bcs = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check({4'h0, reg_rdata}, {4'h0, model_rd(a)});
  endtask : rd_chk

  task automatic wait_src(input logic v);
    for (int k = 0; k < 400 && base_is_vco !== v; k++) @(posedge clk_sys);
    check({11'h0, base_is_vco}, {11'h0, v});
  endtask : wait_src

  task automatic rate_chk(input logic use_vco);
    int nd;
    nd = ({m_hi, m_lo} == 12'h0) ? 1 : int'({m_hi, m_lo});
    xr = 0;
    vr = 0;
    br = 0;
    fp = 0;
    repeat (400) @(posedge clk_sys);
    check({11'h0, ((use_vco ? vr : xr) - br) inside {-1, 0, 1}}, 12'h001);
    check({11'h0, (fp - vr / nd) inside {-1, 0, 1}}, 12'h001);
  endtask : rate_chk

  initial begin
    seed = 29090;
    fails = 0;
    total_checks = 0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    sysint_osc_enable = 1'b1;
    {m_on, m_bcs, m_vpr, m_hi, m_lo, m_rg} = {1'b1, 1'b0, 2'h0, 4'h0, 8'h40, 8'h40};
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) rd_chk(8'h36 + i[7:0]);
    wr(8'h3B, 8'hFF);
    rd_chk(8'h3B);
    // random divisors, then zero which the effective divisor must treat as one
    for (i = 0; i < 5; i++) begin
      wr(8'h38, (i == 4) ? 8'h00 : 8'($random(seed)));
      wr(8'h39, (i == 4) ? 8'h00 : 8'($random(seed)));
      rd_chk(8'h38);
      check(feedback_divisor, ({m_hi, m_lo} == 12'h0) ? 12'h001 : {m_hi, m_lo});
    end
    wr(8'h39, 8'h05);
    wr(8'h36, 8'h21);
    rd_chk(8'h36);
    wr(8'h36, 8'h00);
    wr(8'h36, 8'h02);
    wr(8'h3A, 8'($random(seed)) | 8'h01);
    rd_chk(8'h3A);
    check({1'b0, center_range_code}, {1'b0, 11'(m_rg) << m_vpr});
    wr(8'h36, 8'h12);
    rd_chk(8'h36);
    wr(8'h36, 8'h32);
    rd_chk(8'h36);
    wr(8'h36, 8'h22);
    wr(8'h36, 8'h32);
    wait_src(1'b1);
    rate_chk(1'b1);
    wr(8'h36, 8'h12);
    rd_chk(8'h36);
    wr(8'h3A, 8'h00);
    repeat (2) @(posedge clk_sys);
    check({11'h0, pll_enable_out}, 12'h000);
    wait_src(1'b0);
    rd_chk(8'h36);
    rate_chk(1'b0);
    sysint_osc_enable <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check({10'h0, osc_enable_out, pll_enable_out}, 12'h000);
    close_out();
  end

  initial begin
    #400000;
    fails++;
    close_out();
  end
endmodule : tb
